// *** hw/sleep_wake_reset_cause.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - watchdog wake from sleep clears all four cause flags.
// - watchdog reset while running clears three flags, keeps powerdown flag.
// - reset-pin wake: timeout flag 1, powerdown 0, wake flags 0.
// - power-up: timeout and powerdown flags 1, wake flags 0.
// - reset-pin reset while running clears wake flags, keeps the others.
// - pin-change wake: pin flag and timeout 1, powerdown and comparator 0.
// - comparator wake: comparator flag and timeout 1, pin and powerdown 0.
// - flags hold until the next reset event or sleep entry.
// - sleep entry clears watchdog, sets timeout, clears powerdown, stops oscillator.
// - port outputs and enables frozen throughout sleep.
// - watchdog reset stays internal, never drives the reset pin.
// - sleep ends by device reset on reset pin, watchdog, pin or comparator.
// - pin wake watches pins 0, 1, 3 against last port-access snapshot.
// - every wake from sleep clears the watchdog counter.
// - powerdown flag cleared only by sleep; timeout flag cleared by watchdog.
module sleep_wake_reset_cause #(
  parameter int unsigned WDOG_CYCLES = swrc_pkg::WDOG_DEFAULT_CYCLES
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // avalon-mm slave
  input  wire swrc_pkg::avm_req_s  i_avm,
  output logic [31:0]              o_avm_readdata,
  output logic                     o_avm_waitrequest,
  // processor core
  input  wire logic                i_sleep_exec,
  input  wire logic                i_port_access,
  input  wire logic [3:0]          i_port_out,
  input  wire logic [3:0]          i_port_oe,
  // pins and comparator
  input  wire logic                i_external_reset_pin_n,
  input  wire logic                i_port_pin_0,
  input  wire logic                i_port_pin_1,
  input  wire logic                i_port_pin_3,
  input  wire logic                i_comparator_out,
  // port drivers
  output logic [3:0]               o_port_out,
  output logic [3:0]               o_port_oe,
  output logic                     o_external_reset_pin_out,
  output logic                     o_external_reset_pin_oe,
  // power and reset status
  output logic                     o_device_reset,
  output logic                     o_osc_driver_en,
  output logic                     o_in_sleep,
  output swrc_pkg::flags_s         o_flags
);

  localparam logic [swrc_pkg::WDOG_W-1:0] WDOG_LAST = swrc_pkg::WDOG_W'(WDOG_CYCLES - 1);

  swrc_pkg::state_s      st_r;
  swrc_pkg::state_s      st_nxt;
  logic [4:0]            syn;
  logic                  syn_ext_n;
  logic [2:0]            syn_pins;
  logic                  syn_cmp;
  logic                  sleeping;
  logic                  running;
  logic                  ev_ext;
  logic                  ev_wdog;
  logic                  ev_pin;
  logic                  ev_cmp;
  logic                  ev_any;
  logic                  bus_req;
  logic                  bus_take;

  // every outside level passes two flops before any compare
  sync2 #(
    .WIDTH   (swrc_pkg::SYNC_W),
    .RST_VAL (swrc_pkg::SYNC_RESET)
  ) u_pin_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_external_reset_pin_n, i_port_pin_3, i_port_pin_1, i_port_pin_0,
             i_comparator_out}),
    .o_q   (syn)
  );

  assign syn_ext_n = syn[4];
  assign syn_pins  = syn[3:1];
  assign syn_cmp   = syn[0];

  // wake and reset events; reset-pin, pin and comparator ones from synchronised levels, watchdog from the counter
  assign sleeping = (st_r.mode == swrc_pkg::MODE_SLEEP);
  assign running  = (st_r.mode == swrc_pkg::MODE_RUN);
  assign ev_ext   = st_r.ctrl[swrc_pkg::CTRL_EXTRST_EN_BIT] && st_r.ext_prev && !syn_ext_n;
  assign ev_wdog  = st_r.ctrl[swrc_pkg::CTRL_WDOG_EN_BIT] && (st_r.watchdog_counter == WDOG_LAST);
  // stale snapshot wakes at once; software must read pins first
  assign ev_pin   = sleeping && st_r.ctrl[swrc_pkg::CTRL_PINWAKE_EN_BIT]
                    && (syn_pins != st_r.pin_snap);
  assign ev_cmp   = sleeping && st_r.ctrl[swrc_pkg::CTRL_CMPWAKE_EN_BIT]
                    && (syn_cmp != st_r.cmp_snap);
  assign ev_any   = ev_ext || ev_wdog || ev_pin || ev_cmp;
  assign bus_req  = i_avm.read || i_avm.write;
  assign bus_take = bus_req && !st_r.waitreq;

  // next state: bus slave, watchdog, snapshots and power mode
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.dev_reset = 1'b0;
    st_nxt.waitreq   = 1'b1;
    st_nxt.ext_prev  = syn_ext_n;

    // free-running watchdog, wraps on time-out
    if (!st_r.ctrl[swrc_pkg::CTRL_WDOG_EN_BIT] || ev_wdog)
      st_nxt.watchdog_counter = '0;
    else
      st_nxt.watchdog_counter = st_r.watchdog_counter + 1'b1;

    // snapshot at every file or bit operation on the port
    if (i_port_access)
      st_nxt.pin_snap = syn_pins;

    // outputs follow the core only while awake
    if (!sleeping)
    begin
      st_nxt.port_out = i_port_out;
      st_nxt.port_oe  = i_port_oe;
    end

    // one wait state: answer is prepared on the first edge
    if (bus_req && st_r.waitreq)
    begin
      st_nxt.waitreq = 1'b0;
      case (i_avm.address)
        swrc_pkg::OFS_CTRL:   st_nxt.rdata = {28'h0000000, st_r.ctrl};
        swrc_pkg::OFS_STATUS: st_nxt.rdata = {26'h0, sleeping, st_r.flags.timeout_flag_n,
                                              st_r.flags.powerdown_flag_n, 1'b0,
                                              st_r.flags.pin_wake_flag,
                                              st_r.flags.comparator_wake_flag};
        swrc_pkg::OFS_WDOG:   st_nxt.rdata = {8'h00, st_r.watchdog_counter};
        default:              st_nxt.rdata = 32'h00000000;
      endcase
    end

    // writes take effect on the edge where waitrequest is low
    if (bus_take && i_avm.write && i_avm.byteenable[0])
    begin
      if (i_avm.address == swrc_pkg::OFS_CTRL)
        st_nxt.ctrl = i_avm.writedata[3:0];
      else if (i_avm.address == swrc_pkg::OFS_CMD
               && i_avm.writedata[swrc_pkg::CMD_CLR_WDOG_BIT])
        st_nxt.watchdog_counter = '0;
    end

    // power mode and cause flags; reset pin outranks watchdog
    case (st_r.mode)
      swrc_pkg::MODE_RUN:
      begin
        if (ev_ext)
        begin
          st_nxt.flags.pin_wake_flag        = 1'b0;
          st_nxt.flags.comparator_wake_flag = 1'b0;
          st_nxt.dev_reset                  = 1'b1;
          st_nxt.watchdog_counter           = '0;
          st_nxt.mode                       = swrc_pkg::MODE_WAKE;
        end
        else if (ev_wdog)
        begin
          st_nxt.flags.timeout_flag_n       = 1'b0;
          st_nxt.flags.pin_wake_flag        = 1'b0;
          st_nxt.flags.comparator_wake_flag = 1'b0;
          st_nxt.dev_reset                  = 1'b1;
          st_nxt.mode                       = swrc_pkg::MODE_WAKE;
        end
        else if (i_sleep_exec)
        begin
          st_nxt.flags.timeout_flag_n   = 1'b1;
          st_nxt.flags.powerdown_flag_n = 1'b0;
          st_nxt.watchdog_counter       = '0;
          st_nxt.osc_en                 = 1'b0;
          st_nxt.cmp_snap               = syn_cmp;
          st_nxt.mode                   = swrc_pkg::MODE_SLEEP;
        end
      end
      swrc_pkg::MODE_SLEEP:
      begin
        if (ev_ext)
          st_nxt.flags = 4'h8;
        else if (ev_wdog)
          st_nxt.flags = 4'h0;
        else if (ev_pin)
          st_nxt.flags = 4'ha;
        else if (ev_cmp)
          st_nxt.flags = 4'h9;
        if (ev_any)
        begin
          st_nxt.dev_reset        = 1'b1;
          st_nxt.osc_en           = 1'b1;
          st_nxt.watchdog_counter = '0;
          st_nxt.mode             = swrc_pkg::MODE_WAKE;
        end
      end
      // reset cycle; events here are ignored, flags keep
      swrc_pkg::MODE_WAKE:
        st_nxt.mode = swrc_pkg::MODE_RUN;
      default:
        st_nxt.mode = swrc_pkg::MODE_RUN;
    endcase
  end

  // power-up reset loads the cause flags for power-up
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      st_r <= swrc_pkg::STATE_RESET;
    else
      st_r <= st_nxt;
  end

  // all outputs straight from the state register
  assign o_avm_readdata           = st_r.rdata;
  assign o_avm_waitrequest        = st_r.waitreq;
  assign o_port_out               = st_r.port_out;
  assign o_port_oe                = st_r.port_oe;
  assign o_external_reset_pin_out = st_r.dev_reset & 1'b0;
  assign o_external_reset_pin_oe  = st_r.dev_reset & 1'b0;
  assign o_device_reset           = st_r.dev_reset;
  assign o_osc_driver_en          = st_r.osc_en;
  assign o_in_sleep               = (st_r.mode == swrc_pkg::MODE_SLEEP);
  assign o_flags                  = st_r.flags;

  // checks on the design's own state
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_sleep_entry;
    running && i_sleep_exec && !ev_ext && !ev_wdog;
  endsequence

  sequence s_wake;
    o_device_reset && (st_r.mode == swrc_pkg::MODE_WAKE) ##1 (st_r.mode == swrc_pkg::MODE_RUN);
  endsequence

  a_wdog_sleep_wake: assert property (sleeping && ev_wdog && !ev_ext |=> o_flags == 4'h0)
    else $error("watchdog wake did not clear all flags");

  a_wdog_run_reset: assert property (running && ev_wdog && !ev_ext
    |=> o_flags[3] == 1'b0 && o_flags[1:0] == 2'b00 && o_flags[2] == $past(o_flags[2]))
    else $error("watchdog reset flags wrong");

  a_pin_sleep_wake: assert property (sleeping && ev_ext |=> o_flags == 4'h8)
    else $error("reset pin wake flags wrong");

  a_powerup_flags: assert property (@(posedge i_clk) disable iff (1'b0)
    $past(i_rst) |-> o_flags == 4'hc)
    else $error("power-up flags wrong");

  a_ext_run_reset: assert property (running && ev_ext
    |=> o_flags[1:0] == 2'b00 && o_flags[3:2] == $past(o_flags[3:2]))
    else $error("reset pin reset flags wrong");

  a_pinchg_wake: assert property (sleeping && ev_pin && !ev_ext && !ev_wdog
    |=> o_flags == 4'ha)
    else $error("pin change wake flags wrong");

  a_cmp_wake: assert property (sleeping && ev_cmp && !ev_pin && !ev_ext && !ev_wdog
    |=> o_flags == 4'h9)
    else $error("comparator wake flags wrong");

  a_flags_hold: assert property (!ev_any && !(running && i_sleep_exec) |=> $stable(o_flags))
    else $error("flags changed without a cause");

  a_sleep_entry: assert property (s_sleep_entry |=> o_in_sleep && !o_osc_driver_en
    && o_flags[3:2] == 2'b10 && st_r.watchdog_counter == '0)
    else $error("sleep entry effects missing");

  a_port_frozen: assert property (sleeping ##1 sleeping |-> $stable(o_port_out)
    && $stable(o_port_oe))
    else $error("port changed during sleep");

  a_wdog_internal: assert property (ev_wdog |=> o_device_reset && !o_external_reset_pin_oe)
    else $error("watchdog reset drove the pin");

  a_wake_reset: assert property (sleeping && ev_any |=> s_wake)
    else $error("wake did not pass through device reset");

  a_snap_capture: assert property (i_port_access |=> st_r.pin_snap == $past(syn_pins))
    else $error("pin snapshot not captured");

  a_wake_wdog_clr: assert property (sleeping && ev_any |=> st_r.watchdog_counter == '0)
    else $error("watchdog not cleared on wake");

  a_pd_only_sleep: assert property ($fell(o_flags[2]) |-> $past(running && i_sleep_exec)
    || $past(sleeping && ev_any))
    else $error("powerdown flag cleared without sleep");

  a_sleep_osc_off: assert property (sleeping |-> !o_osc_driver_en)
    else $error("oscillator driver on during sleep");

  a_sleep_stays: assert property (sleeping && !ev_any |=> o_in_sleep)
    else $error("sleep left without a wake event");

  a_wake_osc_on: assert property (sleeping && ev_any
    |=> o_osc_driver_en && !o_in_sleep)
    else $error("wake did not restart the oscillator");

  a_wdog_to_clear: assert property ((running || sleeping) && ev_wdog && !ev_ext
    |=> !o_flags.timeout_flag_n)
    else $error("watchdog time-out left the timeout flag set");

endmodule // sleep_wake_reset_cause

// *** hw/sync2.sv ***
`timescale 1ns/1ps
module sync2 #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  // meta stage feeds only the held stage
  always_comb
  begin
    st_nxt.meta = i_d;
    st_nxt.held = st_r.meta;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      st_r <= '{meta: RST_VAL, held: RST_VAL};
    else
      st_r <= st_nxt;
  end

  assign o_q = st_r.held;

endmodule // sync2

// *** inc/swrc_pkg.sv ***
package swrc_pkg;

  // avalon register map, byte addresses of 32-bit words
  localparam int          AVM_ADDR_W = 4;
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_STATUS = 4'h4;
  localparam logic [3:0]  OFS_CMD    = 4'h8;
  localparam logic [3:0]  OFS_WDOG   = 4'hc;

  // control word fields
  localparam int          CTRL_WDOG_EN_BIT  = 0;
  localparam int          CTRL_EXTRST_EN_BIT = 1;
  localparam int          CTRL_PINWAKE_EN_BIT = 2;
  localparam int          CTRL_CMPWAKE_EN_BIT = 3;
  localparam logic [3:0]  CTRL_RESET        = 4'h3;

  // status word fields
  localparam int          ST_CMP_WAKE_BIT = 0;
  localparam int          ST_PIN_WAKE_BIT = 1;
  localparam int          ST_PWRDN_BIT    = 3;
  localparam int          ST_TIMEOUT_BIT  = 4;
  localparam int          ST_SLEEP_BIT    = 5;

  // command word fields
  localparam int          CMD_CLR_WDOG_BIT = 0;

  // watchdog timing
  localparam int          CLK_PERIOD_NS      = 10;
  localparam int          WDOG_PERIOD_MS     = 18;
  localparam int          WDOG_DEFAULT_CYCLES = WDOG_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          WDOG_W             = 24;

  // pin synchroniser: external reset pin idles high
  localparam int          SYNC_W     = 5;
  localparam logic [4:0]  SYNC_RESET = 5'h10;

  // power mode, gray along run -> sleep -> wake
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_WAKE  = 2'b11
  } mode_e;

  // reset cause flags, timeout and powerdown are active low
  typedef struct packed {
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic pin_wake_flag;
    logic comparator_wake_flag;
  } flags_s;

  localparam flags_s FLAGS_POWERUP = 4'hc;

  // avalon-mm request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avm_req_s;

  // whole state of the sequencer
  typedef struct packed {
    mode_e             mode;
    flags_s            flags;
    logic [3:0]        ctrl;
    logic [WDOG_W-1:0] watchdog_counter;
    logic [2:0]        pin_snap;
    logic              cmp_snap;
    logic              ext_prev;
    logic [3:0]        port_out;
    logic [3:0]        port_oe;
    logic              dev_reset;
    logic              osc_en;
    logic              waitreq;
    logic [31:0]       rdata;
  } state_s;

  localparam state_s STATE_RESET = '{
    mode:             MODE_RUN,
    flags:            FLAGS_POWERUP,
    ctrl:             CTRL_RESET,
    watchdog_counter: 24'h000000,
    pin_snap:         3'h0,
    cmp_snap:         1'h0,
    ext_prev:         1'h1,
    port_out:         4'h0,
    port_oe:          4'h0,
    dev_reset:        1'h1,
    osc_en:           1'h1,
    waitreq:          1'h1,
    rdata:            32'h00000000
  };

endpackage

// *** testbench/sleep_wake_reset_cause_tb.sv ***
`timescale 1ns/1ps
module sleep_wake_reset_cause_tb;
  // short watchdog keeps the run brief
  localparam int unsigned WDOG_N = 50;
  logic               i_clk, i_rst, i_sleep_exec, i_port_access;
  logic [3:0]         i_port_out, i_port_oe, o_port_out, o_port_oe;
  swrc_pkg::avm_req_s i_avm;
  logic [31:0]        o_avm_readdata, rd;
  logic               o_avm_waitrequest, pin_out, pin_oe, pin_n;
  logic               cmp, dev_rst, osc_en, in_sleep, driven;
  logic [2:0]         pins;
  swrc_pkg::flags_s   o_flags;
  int                 num_errors, cmp_count, cycles;

  sleep_wake_reset_cause #(.WDOG_CYCLES(WDOG_N)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_avm(i_avm),
    .o_avm_readdata(o_avm_readdata), .o_avm_waitrequest(o_avm_waitrequest),
    .i_sleep_exec(i_sleep_exec), .i_port_access(i_port_access),
    .i_port_out(i_port_out), .i_port_oe(i_port_oe),
    .i_external_reset_pin_n(pin_n), .i_port_pin_0(pins[0]),
    .i_port_pin_1(pins[1]), .i_port_pin_3(pins[2]), .i_comparator_out(cmp),
    .o_port_out(o_port_out), .o_port_oe(o_port_oe),
    .o_external_reset_pin_out(pin_out), .o_external_reset_pin_oe(pin_oe),
    .o_device_reset(dev_rst), .o_osc_driver_en(osc_en),
    .o_in_sleep(in_sleep), .o_flags(o_flags)
  );
  swrc_far_side far (
    .i_clk(i_clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_pin_n(pin_n),
    .o_pins(pins), .o_cmp(cmp), .o_driven(driven)
  );

  // clock
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, whole run needs under a thousand cycles
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_avm.read <= ~wr;
    i_avm.write <= wr;
    i_avm.byteenable <= 4'hf;
    i_avm.address <= a;
    i_avm.writedata <= d;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_avm_waitrequest !== 1'b0 && n < 20);
    chk(o_avm_waitrequest, 0);
    rd = o_avm_readdata;
    i_avm.read <= 1'b0;
    i_avm.write <= 1'b0;
  endtask

  // port access pulse, refreshes the pin snapshot
  task automatic snap();
    @(posedge i_clk);
    i_port_access <= 1'b1;
    @(posedge i_clk);
    i_port_access <= 1'b0;
  endtask

  task automatic go_sleep();
    @(posedge i_clk);
    i_sleep_exec <= 1'b1;
    @(posedge i_clk);
    i_sleep_exec <= 1'b0;
    @(posedge i_clk);
    chk(in_sleep, 1);
    chk(osc_en, 0);
    chk(o_flags[3:2], 2'b10);
  endtask

  // wait for the reset pulse, flags are valid in that same cycle
  task automatic wake(input logic [3:0] exp);
    int n;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (dev_rst !== 1'b1 && n < 80);
    chk(dev_rst, 1);
    chk(o_flags, exp);
    chk(osc_en, 1);
  endtask

  initial
  begin
    i_rst = 1'b1;
    i_sleep_exec = 1'b0;
    i_port_access = 1'b0;
    i_port_out = 4'h0;
    i_port_oe = 4'h0;
    i_avm = '0;
    num_errors = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    chk(o_flags, swrc_pkg::FLAGS_POWERUP);
    bus(0, swrc_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h18);
    bus(0, swrc_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h3);
    bus(0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    // watchdog is on out of reset and fires while running
    wake(4'h4);
    bus(1, swrc_pkg::OFS_CTRL, 32'he);
    repeat (20) @(posedge i_clk);
    chk(o_flags, 4'h4);
    // each watched pin wakes, ports stay frozen meanwhile
    for (int k = 0; k < 3; k++)
    begin
      i_port_out <= 4'h5;
      i_port_oe <= 4'h3;
      snap();
      go_sleep();
      i_port_out <= 4'ha;
      i_port_oe <= 4'hc;
      repeat (8) @(posedge i_clk);
      chk(in_sleep, 1);
      chk(o_port_out, 4'h5);
      chk(o_port_oe, 4'h3);
      far.flip_pin(k);
      wake(4'ha);
    end
    fork
      far.press(3);
      wake(4'h8);
    join
    // pin moved with no port access, so sleep ends at once
    far.flip_pin(0);
    repeat (4) @(posedge i_clk);
    go_sleep();
    wake(4'ha);
    snap();
    go_sleep();
    far.flip_cmp();
    wake(4'h9);
    go_sleep();
    fork
      far.press(2);
      wake(4'h8);
    join
    // pin and comparator wake off, the watchdog must restart at sleep
    bus(1, swrc_pkg::OFS_CTRL, 32'h3);
    repeat (30) @(posedge i_clk);
    snap();
    go_sleep();
    far.flip_pin(1);
    far.flip_cmp();
    repeat (40) @(posedge i_clk);
    chk(in_sleep, 1);
    wake(4'h0);
    bus(0, swrc_pkg::OFS_WDOG, 32'h0);
    chk({31'h0, rd < 32'h8}, 32'h1);
    // pin wake with the watchdog running: the wake itself must restart it
    bus(1, swrc_pkg::OFS_CTRL, 32'h7);
    snap();
    go_sleep();
    repeat (30) @(posedge i_clk);
    far.flip_pin(0);
    wake(4'ha);
    bus(0, swrc_pkg::OFS_WDOG, 32'h0);
    chk({31'h0, rd < 32'h8}, 32'h1);
    chk(driven, 0);
    test_done();
  end
endmodule // sleep_wake_reset_cause_tb

// *** testbench/swrc_far_side.sv ***
`timescale 1ns/1ps
// far side: reset pin with pull-up, watched port pins, comparator
module swrc_far_side (
  // clock
  input  wire logic  i_clk,
  // device drive of the reset pin
  input  wire logic  i_pin_out,
  input  wire logic  i_pin_oe,
  // levels seen by the device
  output logic       o_pin_n,
  output logic [2:0] o_pins,
  output logic       o_cmp,
  // sticky, device ever drove the reset pin
  output logic       o_driven
);
  logic press_n = 1'b1;
  initial
  begin
    o_pins = 3'h0;
    o_cmp = 1'b0;
    o_driven = 1'b0;
  end
  // pull-up holds the pin high unless somebody pulls it low
  assign o_pin_n = i_pin_oe ? i_pin_out : press_n;
  // a watchdog reset must stay inside the device
  always @(posedge i_clk)
    if (i_pin_oe === 1'b1)
      o_driven <= 1'b1;
  // long presses model a slow button, short ones a glitchy one
  task automatic press(input int len);
    @(posedge i_clk);
    press_n <= 1'b0;
    repeat (len) @(posedge i_clk);
    press_n <= 1'b1;
  endtask
  // edges land on the clock edge, the device syncs them anyway
  task automatic flip_pin(input int k);
    @(posedge i_clk);
    o_pins[k] <= ~o_pins[k];
  endtask
  task automatic flip_cmp();
    @(posedge i_clk);
    o_cmp <= ~o_cmp;
  endtask
endmodule // swrc_far_side
